// ### src/arf_frame_builder.sv
/*
  Builds command response, transmit status and receive frames
  and streams them byte by byte to the serial side.
  Assumes each event source holds its fields while valid is high,
  and that payload bytes arrive in order.
*/
// The AXI4-Lite slave port and the placing of the registers were left to the implementer.
// Summary of operation
// - command request answers go out as type 0x88 frames.
// - several command responses may follow one request; each event is one frame.
// - byte 4 echoes the frame id; id zero suppresses the response.
// - bytes 5-6 echo the two ASCII command characters.
// - byte 7 holds status: ok, error, unknown command, bad parameter.
// - command data from byte 8 on, omitted when the register was written.
// - finished legacy transmit requests are reported in a 0x89 frame.
// - byte 4 of the 0x89 frame repeats the request's frame id.
// - byte 5 is 0x00 for normal completion, 0x01 for no acknowledgement.
// - receive format 0 forwards packets as type 0x90 frames.
// - 0x90 bytes 4-11 sender address msb first, 12-13 reserved.
// - 0x90 byte 14 options: 0x01 acknowledged, 0x02 broadcast.
// - 0x90 payload follows in order from byte 15.
// - receive format 1 forwards packets as type 0x91 frames.
// - 0x91 bytes 4-11 sender address msb first, 12-13 reserved.
// - 0x91 byte 14 source endpoint, byte 15 destination endpoint.
// - 0x91 bytes 16-17 cluster id, 18-19 profile id.
// - 0x91 byte 20 options, data from byte 21; host ignores other bits.
// - senders using a 0x10 request report the default endpoints and cluster.
// - receive format 2 forwards packets in the legacy 0x80 frame.
`timescale 1ns/10ps
`include "arf_consts.svh"
module arf_frame_builder (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [7:0] cmd_frame_id,
  input wire logic [15:0] cmd_name,
  input wire arf_pkg::arf_cmd_status_t cmd_status,
  input wire logic cmd_has_data,
  input wire logic [7:0] cmd_data_len,
  input wire logic txs_valid,
  output logic txs_ready,
  input wire logic [7:0] txs_frame_id,
  input wire logic txs_no_ack,
  input wire logic rx_valid,
  output logic rx_ready,
  input wire logic [63:0] rx_src_addr,
  input wire logic rx_acked,
  input wire logic rx_bcast,
  input wire logic [7:0] rx_rssi,
  input wire logic rx_sender_explicit,
  input wire logic [7:0] rx_src_ep,
  input wire logic [7:0] rx_dst_ep,
  input wire logic [15:0] rx_cluster,
  input wire logic [15:0] rx_profile,
  input wire logic [7:0] rx_data_len,
  input wire logic pl_valid,
  output logic pl_ready,
  input wire logic [7:0] pl_data,
  output logic ser_valid,
  input wire logic ser_ready,
  output logic [7:0] ser_data
);
  arf_cfg_if cfg ();

  arf_pkg::arf_state_t state_ff, nxt_state;
  logic [7:0] hdr_ff [0:`ARF_HDR_MAX-1];
  logic [7:0] hdr_c [0:`ARF_HDR_MAX-1];
  logic [4:0] hlen_ff, hlen_c, idx_ff, nxt_idx;
  logic [7:0] cnt_ff, nxt_cnt, plen_c, opts_c, csum;
  logic [15:0] len_ff, sent_cnt_ff, drop_cnt_ff;
  logic suppress_c, any_req, ack_busy, cap, can_load, pl_take;
  logic out_load, csum_add, sent_evt;
  logic [7:0] out_byte;
  logic nxt_pl_ready;

  arf_axil_regs u_regs (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .cfg(cfg.regs)
  );

  arf_checksum u_csum (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clear(cap),
    .add(csum_add),
    .data(out_byte),
    .csum(csum)
  );

  assign cfg.busy = state_ff != arf_pkg::ST_IDLE;
  assign cfg.sent_cnt = sent_cnt_ff;
  assign cfg.drop_cnt = drop_cnt_ff;

  // ready rises a cycle after capture, so idle must not
  // recapture the same request meanwhile
  assign any_req = cmd_valid || txs_valid || rx_valid;
  assign ack_busy = cmd_ready || txs_ready || rx_ready;
  assign cap = state_ff == arf_pkg::ST_IDLE && any_req && !ack_busy;
  assign can_load = !ser_valid || ser_ready;
  assign pl_take = pl_valid && pl_ready;

  // header image of the winning source; cmd beats status beats rx
  always_comb begin
    for (int i = 0; i < `ARF_HDR_MAX; i++) begin
      hdr_c[i] = 8'h00;
    end
    hlen_c = 5'h00;
    plen_c = 8'h00;
    suppress_c = 1'b0;
    opts_c = (rx_acked ? `ARF_OPT_ACK : 8'h00) | (rx_bcast ? `ARF_OPT_BCAST : 8'h00);
    if (cmd_valid) begin
      hdr_c[0] = `ARF_T_CMD_RESP;
      hdr_c[1] = cmd_frame_id;
      hdr_c[2] = cmd_name[15:8];
      hdr_c[3] = cmd_name[7:0];
      hdr_c[4] = cmd_status;
      hlen_c = `ARF_HLEN_CMD;
      plen_c = cmd_has_data ? cmd_data_len : 8'h00;
      suppress_c = cmd_frame_id == `ARF_NO_ID;
    end else if (txs_valid) begin
      hdr_c[0] = `ARF_T_TX_STAT;
      hdr_c[1] = txs_frame_id;
      hdr_c[2] = txs_no_ack ? `ARF_TXS_NOACK : `ARF_TXS_OK;
      hlen_c = `ARF_HLEN_TXS;
    end else if (rx_valid) begin
      plen_c = rx_data_len;
      for (int k = 0; k < 8; k++) begin
        hdr_c[1 + k] = rx_src_addr[63 - 8*k -: 8];
      end
      case (cfg.rx_frame_format_select)
        `ARF_FMT_EXPL: begin
          hdr_c[0] = `ARF_T_RX_EXPL;
          hdr_c[9] = `ARF_RSVD_HI;
          hdr_c[10] = `ARF_RSVD_LO;
          // plain-request senders report our defaults
          hdr_c[11] = rx_sender_explicit ? rx_src_ep : cfg.src_endpoint_param;
          hdr_c[12] = rx_sender_explicit ? rx_dst_ep : cfg.dst_endpoint_param;
          hdr_c[13] = rx_sender_explicit ? rx_cluster[15:8] : cfg.cluster_ident_param[15:8];
          hdr_c[14] = rx_sender_explicit ? rx_cluster[7:0] : cfg.cluster_ident_param[7:0];
          hdr_c[15] = rx_profile[15:8];
          hdr_c[16] = rx_profile[7:0];
          hdr_c[17] = opts_c;
          hlen_c = `ARF_HLEN_EXPL;
        end
        `ARF_FMT_LEGACY: begin
          hdr_c[0] = `ARF_T_RX_LEGACY;
          hdr_c[9] = rx_rssi;
          hdr_c[10] = opts_c;
          hlen_c = `ARF_HLEN_LEGACY;
        end
        default: begin
          // unused format code 3 falls back to the standard frame
          hdr_c[0] = `ARF_T_RX_STD;
          hdr_c[9] = `ARF_RSVD_HI;
          hdr_c[10] = `ARF_RSVD_LO;
          hdr_c[11] = opts_c;
          hlen_c = `ARF_HLEN_STD;
        end
      endcase
    end
  end

  // byte sequencer: one byte into the output register at a time
  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_cnt = cnt_ff;
    out_load = 1'b0;
    out_byte = 8'h00;
    csum_add = 1'b0;
    sent_evt = 1'b0;
    case (state_ff)
      arf_pkg::ST_IDLE: begin
        if (cap) begin
          nxt_cnt = plen_c;
          nxt_idx = 5'h00;
          if (suppress_c) begin
            nxt_state = plen_c != 8'h00 ? arf_pkg::ST_DROP : arf_pkg::ST_IDLE;
          end else begin
            nxt_state = arf_pkg::ST_DELIM;
          end
        end
      end
      arf_pkg::ST_DELIM: begin
        out_byte = `ARF_DELIM;
        if (can_load) begin
          out_load = 1'b1;
          nxt_state = arf_pkg::ST_LEN_HI;
        end
      end
      arf_pkg::ST_LEN_HI: begin
        out_byte = len_ff[15:8];
        if (can_load) begin
          out_load = 1'b1;
          nxt_state = arf_pkg::ST_LEN_LO;
        end
      end
      arf_pkg::ST_LEN_LO: begin
        out_byte = len_ff[7:0];
        if (can_load) begin
          out_load = 1'b1;
          nxt_state = arf_pkg::ST_HDR;
        end
      end
      arf_pkg::ST_HDR: begin
        out_byte = hdr_ff[idx_ff];
        if (can_load) begin
          out_load = 1'b1;
          csum_add = 1'b1;
          nxt_idx = idx_ff + 5'h01;
          if (idx_ff == hlen_ff - 5'h01) begin
            nxt_state = cnt_ff != 8'h00 ? arf_pkg::ST_PAYLOAD : arf_pkg::ST_CSUM;
          end
        end
      end
      arf_pkg::ST_PAYLOAD: begin
        out_byte = pl_data;
        if (pl_take) begin
          out_load = 1'b1;
          csum_add = 1'b1;
          nxt_cnt = cnt_ff - 8'h01;
          if (cnt_ff == 8'h01) begin
            nxt_state = arf_pkg::ST_CSUM;
          end
        end
      end
      arf_pkg::ST_CSUM: begin
        out_byte = csum;
        if (can_load) begin
          out_load = 1'b1;
          sent_evt = 1'b1;
          nxt_state = arf_pkg::ST_IDLE;
        end
      end
      arf_pkg::ST_DROP: begin
        if (pl_take) begin
          nxt_cnt = cnt_ff - 8'h01;
          if (cnt_ff == 8'h01) begin
            nxt_state = arf_pkg::ST_IDLE;
          end
        end
      end
      default: nxt_state = arf_pkg::ST_IDLE;
    endcase
  end

  // in ST_PAYLOAD, payload ready rises only when the output register will be free,
  // so a taken byte never waits; this halves payload throughput
  always_comb begin
    case (state_ff)
      arf_pkg::ST_PAYLOAD: nxt_pl_ready = pl_take ? 1'b0 : (pl_ready || can_load);
      arf_pkg::ST_DROP: nxt_pl_ready = pl_take ? cnt_ff != 8'h01 : 1'b1;
      default: nxt_pl_ready = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff <= arf_pkg::ST_IDLE;
      idx_ff <= 5'h00;
      cnt_ff <= 8'h00;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < `ARF_HDR_MAX; i++) begin
        hdr_ff[i] <= 8'h00;
      end
      hlen_ff <= 5'h00;
      len_ff <= 16'h0000;
    end else if (cap) begin
      hdr_ff <= hdr_c;
      hlen_ff <= hlen_c;
      len_ff <= {11'h000, hlen_c} + {8'h00, plen_c};
    end
  end

  // each event is acknowledged alone; repeated answers to one request
  // arrive as further command events
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cmd_ready <= 1'b0;
      txs_ready <= 1'b0;
      rx_ready <= 1'b0;
    end else begin
      cmd_ready <= cap && cmd_valid;
      txs_ready <= cap && !cmd_valid && txs_valid;
      rx_ready <= cap && !cmd_valid && !txs_valid && rx_valid;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      pl_ready <= 1'b0;
    end else begin
      pl_ready <= nxt_pl_ready;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ser_valid <= 1'b0;
      ser_data <= 8'h00;
    end else if (out_load) begin
      ser_valid <= 1'b1;
      ser_data <= out_byte;
    end else if (ser_ready) begin
      ser_valid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sent_cnt_ff <= 16'h0000;
      drop_cnt_ff <= 16'h0000;
    end else begin
      if (sent_evt) begin
        sent_cnt_ff <= sent_cnt_ff + 16'h0001;
      end
      if (cap && suppress_c) begin
        drop_cnt_ff <= drop_cnt_ff + 16'h0001;
      end
    end
  end
endmodule : arf_frame_builder

// ### src/arf_consts.svh
/*
  Frame builder constants: frame bytes, header lengths,
  register offsets and reset values.
  Assumes inclusion by bare name.
*/
`ifndef ARF_CONSTS_SVH
`define ARF_CONSTS_SVH

`define ARF_DELIM 8'h7e
`define ARF_T_CMD_RESP 8'h88
`define ARF_T_TX_STAT 8'h89
`define ARF_T_RX_STD 8'h90
`define ARF_T_RX_EXPL 8'h91
`define ARF_T_RX_LEGACY 8'h80
`define ARF_RSVD_HI 8'hff
`define ARF_RSVD_LO 8'hfe
`define ARF_OPT_ACK 8'h01
`define ARF_OPT_BCAST 8'h02
`define ARF_TXS_OK 8'h00
`define ARF_TXS_NOACK 8'h01
`define ARF_CSUM_BASE 8'hff
`define ARF_NO_ID 8'h00

`define ARF_HLEN_CMD 5'h05
`define ARF_HLEN_TXS 5'h03
`define ARF_HLEN_STD 5'h0c
`define ARF_HLEN_EXPL 5'h12
`define ARF_HLEN_LEGACY 5'h0b
`define ARF_HDR_MAX 18

`define ARF_FMT_STD 2'h0
`define ARF_FMT_EXPL 2'h1
`define ARF_FMT_LEGACY 2'h2

`define ARF_REG_CTRL 8'h00
`define ARF_REG_DFLT 8'h04
`define ARF_REG_STAT 8'h08
`define ARF_REG_CNT 8'h0c
`define ARF_CTRL_RST 2'h0
`define ARF_DFLT_RST 32'h0011_e8e8
`define ARF_RESP_OKAY 2'h0
`define ARF_RESP_SLVERR 2'h2

`endif

// ### src/arf_pkg.sv
/*
  Types for the frame builder.
  Assumes nothing.
*/
package arf_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DELIM,
    ST_LEN_HI,
    ST_LEN_LO,
    ST_HDR,
    ST_PAYLOAD,
    ST_CSUM,
    ST_DROP
  } arf_state_t;

  // declaration order gives the status byte
  typedef enum logic [7:0] {
    CMD_OK,
    CMD_ERROR,
    CMD_BAD_CMD,
    CMD_BAD_PARAM
  } arf_cmd_status_t;

endpackage : arf_pkg

// ### src/arf_cfg_if.sv
/*
  Configuration and status carrier between
  register slave and sequencer.
  Assumes one clock.
*/
`timescale 1ns/10ps
interface arf_cfg_if;
  logic [1:0] rx_frame_format_select;
  logic [7:0] src_endpoint_param;
  logic [7:0] dst_endpoint_param;
  logic [15:0] cluster_ident_param;
  logic busy;
  logic [15:0] sent_cnt;
  logic [15:0] drop_cnt;

  modport regs (
    output rx_frame_format_select,
    output src_endpoint_param,
    output dst_endpoint_param,
    output cluster_ident_param,
    input busy,
    input sent_cnt,
    input drop_cnt
  );

  modport core (
    input rx_frame_format_select,
    input src_endpoint_param,
    input dst_endpoint_param,
    input cluster_ident_param,
    output busy,
    output sent_cnt,
    output drop_cnt
  );
endinterface : arf_cfg_if

// ### src/arf_checksum.sv
/*
  Running checksum over the frame data bytes.
  Assumes clear and add never coincide.
*/
`timescale 1ns/10ps
`include "arf_consts.svh"
module arf_checksum (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clear,
  input wire logic add,
  input wire logic [7:0] data,
  output logic [7:0] csum
);
  logic [7:0] sum_ff;

  always_ff @(posedge core_clk) begin
    if (sys_rst || clear) begin
      sum_ff <= 8'h00;
    end else if (add) begin
      sum_ff <= sum_ff + data;
    end
  end

  // wrap is intended: only the low byte counts
  assign csum = `ARF_CSUM_BASE - sum_ff;
endmodule : arf_checksum

// ### src/arf_axil_regs.sv
/*
  AXI4-Lite slave with the control and default registers
  and the sequencer's status.
  Assumes one read and one write outstanding at most.
*/
`timescale 1ns/10ps
`include "arf_consts.svh"
module arf_axil_regs (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  arf_cfg_if.regs cfg
);
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic aw_have_ff, w_have_ff;
  logic [1:0] fmt_ff;
  logic [31:0] dflt_ff;
  logic aw_take, w_take, do_write, b_take, ar_take, r_take, wr_hit;
  logic nxt_aw_have, nxt_w_have, nxt_bvalid;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign do_write = aw_have_ff && w_have_ff && !s_axi_bvalid;
  assign b_take = s_axi_bvalid && s_axi_bready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign r_take = s_axi_rvalid && s_axi_rready;
  assign wr_hit = awaddr_ff == `ARF_REG_CTRL || awaddr_ff == `ARF_REG_DFLT ||
                  awaddr_ff == `ARF_REG_STAT || awaddr_ff == `ARF_REG_CNT;
  assign nxt_aw_have = aw_take ? 1'b1 : (do_write ? 1'b0 : aw_have_ff);
  assign nxt_w_have = w_take ? 1'b1 : (do_write ? 1'b0 : w_have_ff);
  assign nxt_bvalid = do_write ? 1'b1 : (b_take ? 1'b0 : s_axi_bvalid);

  // address and data taken in either order
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ARF_RESP_OKAY;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else begin
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      s_axi_awready <= !nxt_aw_have && !nxt_bvalid;
      s_axi_wready <= !nxt_w_have && !nxt_bvalid;
      s_axi_bvalid <= nxt_bvalid;
      if (aw_take) begin
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bresp <= wr_hit ? `ARF_RESP_OKAY : `ARF_RESP_SLVERR;
      end
    end
  end

  // status and counter words ignore writes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      fmt_ff <= `ARF_CTRL_RST;
      dflt_ff <= `ARF_DFLT_RST;
    end else if (do_write) begin
      if (awaddr_ff == `ARF_REG_CTRL && wstrb_ff[0]) begin
        fmt_ff <= wdata_ff[1:0];
      end
      if (awaddr_ff == `ARF_REG_DFLT) begin
        for (int b = 0; b < 4; b++) begin
          if (wstrb_ff[b]) begin
            dflt_ff[8*b +: 8] <= wdata_ff[8*b +: 8];
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `ARF_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `ARF_RESP_OKAY;
      case (s_axi_araddr)
        `ARF_REG_CTRL: s_axi_rdata <= {30'h0000_0000, fmt_ff};
        `ARF_REG_DFLT: s_axi_rdata <= dflt_ff;
        `ARF_REG_STAT: s_axi_rdata <= {31'h0000_0000, cfg.busy};
        `ARF_REG_CNT: s_axi_rdata <= {cfg.drop_cnt, cfg.sent_cnt};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `ARF_RESP_SLVERR;
        end
      endcase
    end else if (r_take || !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  assign cfg.rx_frame_format_select = fmt_ff;
  assign cfg.src_endpoint_param = dflt_ff[7:0];
  assign cfg.dst_endpoint_param = dflt_ff[15:8];
  assign cfg.cluster_ident_param = dflt_ff[31:16];
endmodule : arf_axil_regs

// ### verif/arf_frame_builder_checker.sv
/*
  Port assertions for the frame builder, bound to its top module.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
module arf_frame_builder_checker (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cmd_ready,
  input wire logic [7:0] cmd_frame_id,
  input wire logic txs_ready,
  input wire logic rx_ready,
  input wire logic ser_valid,
  input wire logic ser_ready,
  input wire logic [7:0] ser_data
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  a_ser_hold: assert property (ser_valid && !ser_ready |=> ser_valid && $stable(ser_data))
    else $error("byte changed in stall");
  a_open_delim: assert property ((txs_ready || rx_ready) && !ser_valid
    |=> ser_data == 8'h7e) else $error("no delimiter");
  a_txs_start: assert property (txs_ready && !ser_valid |=> ser_valid)
    else $error("no status frame");
  a_rx_start: assert property (rx_ready && !ser_valid |=> ser_valid)
    else $error("no receive frame");
  a_cmd_start: assert property (cmd_ready && cmd_frame_id != 8'h00 && !ser_valid
    |=> ser_valid) else $error("no command frame");
  a_cmd_quiet: assert property (cmd_ready && cmd_frame_id == 8'h00 && !ser_valid
    |=> !ser_valid [*2]) else $error("frame for zero id");
  a_one_event: assert property ($onehot0({cmd_ready, txs_ready, rx_ready}))
    else $error("two events at once");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("read answer dropped");
  c_cmd: cover property (cmd_ready);
  c_rx: cover property (rx_ready);
  c_stall: cover property (ser_valid && !ser_ready);
endmodule : arf_frame_builder_checker

bind arf_frame_builder arf_frame_builder_checker chk (.core_clk, .sys_rst, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .cmd_ready, .cmd_frame_id, .txs_ready,
  .rx_ready, .ser_valid, .ser_ready, .ser_data);

// ### verif/arf_host_model.sv
/*
  Host end of the serial byte stream; keeps each accepted byte.
  Assumes the bench reads and clears the queue.
*/
`timescale 1ns/10ps
module arf_host_model (
  input wire logic core_clk,
  input wire logic stall,
  input wire logic ser_valid,
  input wire logic [7:0] ser_data,
  output logic ser_ready
);
  logic [7:0] got[$];
  initial ser_ready = 1'b0;
  // stall toggles ready to exercise byte holding
  always @(posedge core_clk) begin
    if (ser_valid && ser_ready) got.push_back(ser_data);
    ser_ready <= stall ? !ser_ready : 1'b1;
  end
endmodule : arf_host_model

// ### verif/arf_frame_builder_test.sv
/*
  Self-checking bench for the frame builder, host model on the serial side.
  Assumes registered handshakes on every interface.
*/
`timescale 1ns/10ps
module arf_frame_builder_test;
  logic core_clk = 1'b0, sys_rst = 1'b1, stall = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, pl_valid = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, pl_data = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic cmd_valid = 1'b0, cmd_has_data = 1'b0, txs_valid = 1'b0, txs_no_ack = 1'b0;
  logic rx_valid = 1'b0, rx_acked = 1'b0, rx_bcast = 1'b0, rx_sender_explicit = 1'b0;
  logic [7:0] cmd_frame_id = 8'h01, cmd_data_len = 8'h00, txs_frame_id = 8'h01;
  logic [7:0] rx_rssi = 8'h28, rx_data_len = 8'h06, rx_src_ep = 8'he0, rx_dst_ep = 8'he0;
  logic [15:0] cmd_name = 16'h4244, rx_cluster = 16'h2211, rx_profile = 16'hc105;
  logic [63:0] rx_src_addr = 64'h0013_a200_4052_2baa;
  arf_pkg::arf_cmd_status_t cmd_status = arf_pkg::CMD_OK;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic cmd_ready, txs_ready, rx_ready, pl_ready, ser_valid, ser_ready;
  logic [7:0] ser_data;
  logic [7:0] ex[$], pl[$];
  int mismatches = 0, compares = 0, cyc = 0;

  arf_frame_builder DUT (.core_clk, .sys_rst, .s_axi_awaddr, .s_axi_awprot(3'h0),
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cmd_valid, .cmd_ready, .cmd_frame_id, .cmd_name,
    .cmd_status, .cmd_has_data, .cmd_data_len, .txs_valid, .txs_ready, .txs_frame_id,
    .txs_no_ack, .rx_valid, .rx_ready, .rx_src_addr, .rx_acked, .rx_bcast, .rx_rssi,
    .rx_sender_explicit, .rx_src_ep, .rx_dst_ep, .rx_cluster, .rx_profile, .rx_data_len,
    .pl_valid, .pl_ready, .pl_data, .ser_valid, .ser_ready, .ser_data);
  arf_host_model host (.core_clk, .stall, .ser_valid, .ser_data, .ser_ready);

  initial forever #5 core_clk = ~core_clk;

  task tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic cmp(input string w, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask : cmp

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    bit pa = 1;
    bit pw = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (pa || pw) begin
      @(posedge core_clk);
      if (pa && s_axi_awready) begin
        pa = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (pw && s_axi_wready) begin
        pw = 0;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmp("bresp", 32'(r), 32'(s_axi_bresp));
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    cmp("rdata", d, s_axi_rdata);
    cmp("rresp", 32'(r), 32'(s_axi_rresp));
  endtask : axr

  // event, then payload bytes
  task automatic fire(input int k);
    @(posedge core_clk);
    {rx_valid, txs_valid, cmd_valid} <= 3'b001 << k;
    do @(posedge core_clk); while ((cmd_ready | txs_ready | rx_ready) !== 1'b1);
    {rx_valid, txs_valid, cmd_valid} <= 3'b000;
    foreach (pl[i]) begin
      pl_valid <= 1'b1;
      pl_data <= pl[i];
      do @(posedge core_clk); while (pl_ready !== 1'b1);
    end
    pl_valid <= 1'b0;
  endtask : fire

  task automatic expect_frame(input string w);
    logic [7:0] f[$];
    logic [7:0] s = 8'hff;
    f = {ex, pl};
    foreach (f[i]) s -= f[i];
    f = {8'h7e, 8'h00, 8'(f.size()), f, s};
    while (host.got.size() < f.size()) @(posedge core_clk);
    foreach (f[i]) cmp(w, 32'(f[i]), 32'(host.got[i]));
    host.got.delete();
  endtask : expect_frame

  task automatic t_cmd;
    for (int s = 0; s < 4; s++) begin
      cmd_status <= arf_pkg::arf_cmd_status_t'(s);
      cmd_has_data <= (s != 0);
      pl.delete();
      if (s != 0) pl = {8'(s), 8'ha5};
      cmd_data_len <= 8'(pl.size());
      ex = {8'h88, 8'h01, 8'h42, 8'h44, 8'(s)};
      fire(0);
      expect_frame("cmd");
    end
    cmd_frame_id <= 8'h00;
    cmd_data_len <= 8'h01;
    pl = {8'h5a};
    fire(0);
    $display("test cmd done");
  endtask : t_cmd

  task automatic t_txs;
    pl.delete();
    for (int n = 0; n < 2; n++) begin
      txs_no_ack <= n[0];
      ex = {8'h89, 8'h01, 8'(n)};
      fire(1);
      expect_frame("txs");
    end
    $display("test txs done");
  endtask : t_txs

  // pass 3: format 1, plain sender; pass 4: unused format code 3
  task automatic t_rx;
    logic [31:0] v;
    stall <= 1'b1;
    pl = {8'h52, 8'h78, 8'h44, 8'h61, 8'h74, 8'h61};
    for (int f = 0; f < 5; f++) begin
      v = 32'(f == 3 ? 1 : f == 4 ? 3 : f);
      axw(8'h00, v, 2'h0);
      axr(8'h00, v, 2'h0);
      rx_acked <= !f[0];
      rx_bcast <= f[0];
      rx_sender_explicit <= (f != 3);
      ex = {(f == 2) ? 8'h80 : (f == 0 || f == 4) ? 8'h90 : 8'h91};
      for (int i = 7; i >= 0; i--) ex.push_back(rx_src_addr[8*i +: 8]);
      if (f == 2) ex.push_back(8'h28);
      else ex = {ex, 8'hff, 8'hfe};
      if (f == 1) ex = {ex, 8'he0, 8'he0, 8'h22, 8'h11, 8'hc1, 8'h05};
      if (f == 3) ex = {ex, 8'he8, 8'he8, 8'h00, 8'h11, 8'hc1, 8'h05};
      ex.push_back(f[0] ? 8'h02 : 8'h01);
      fire(2);
      expect_frame("rx");
    end
    stall <= 1'b0;
    $display("test rx done");
  endtask : t_rx

  initial begin
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    axr(8'h04, 32'h0011_e8e8, 2'h0);
    axr(8'h10, 32'h0000_0000, 2'h2);
    axw(8'h14, 32'h0000_0003, 2'h2);
    t_cmd();
    t_txs();
    t_rx();
    axr(8'h0c, 32'h0001_000b, 2'h0);
    tally_and_finish();
  end
endmodule : arf_frame_builder_test
